// file: shared/ttr_pkg.sv
package ttr_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 12'h300;
  localparam logic [IDX_W-1:0] IDX_TEST_CONTROL = 12'h32C;
  localparam logic [IDX_W-1:0] IDX_REF_LOW = 12'h32D;
  localparam logic [IDX_W-1:0] IDX_REF_HIGH = 12'h32E;
  localparam logic [IDX_W-1:0] IDX_COMP_RESULT = 12'h32F;
  localparam logic [IDX_W-1:0] IDX_INV_MASK = 12'h334;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h3F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h3F1;
  localparam logic [IDX_W-1:0] IDX_RX_DEVICE = 12'h400;
  localparam logic [IDX_W-1:0] IDX_RX_BANK = 12'h401;
  localparam logic [IDX_W-1:0] IDX_RX_LANE = 12'h402;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_SAMPLE_LSB = 4;
  localparam int CTRL_CHANNEL_LSB = 2;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int COMP_SELECT_BIT = 6;
  localparam int COMP_FAIL_BIT = 0;
  localparam int LANE_ADJDIR_BIT = 6;
  localparam int LANE_PHADJ_BIT = 5;
  localparam int IRQ_MISMATCH_BIT = 0;
  localparam int IRQ_ILAS_BIT = 1;
  localparam int IRQ_W = 2;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] CHANNEL_NONE = 2'h3;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

endpackage

// file: core/ttr_lane_invert.sv
`timescale 1ns/1ps
module ttr_lane_invert #(
  parameter int LANES = 8,
  parameter int LANE_W = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [LANES*LANE_W-1:0] lane_data_in,
  input wire logic lane_valid_in,
  input wire logic [LANES-1:0] lane_invert_mask_in,
  output logic [LANES*LANE_W-1:0] lane_data_out,
  output logic lane_valid_out
);

  // ------------------------------------------------------------
  // per-lane polarity flip
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          lane_data_out[g*LANE_W +: LANE_W] <= '0;
        end else begin
          lane_data_out[g*LANE_W +: LANE_W] <= lane_data_in[g*LANE_W +: LANE_W]
            ^ {LANE_W{lane_invert_mask_in[g]}};
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lane_valid_out <= 1'b0;
    end else begin
      lane_valid_out <= lane_valid_in;
    end
  end

endmodule

// file: core/ttr_ilas_capture.sv
`timescale 1ns/1ps
module ttr_ilas_capture #(
  parameter int LINKS = 2,
  parameter int PAGE_W = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [LINKS-1:0] ilas_valid_in,
  input wire logic [LINKS*8-1:0] ilas_device_id_in,
  input wire logic [LINKS*8-1:0] ilas_bank_id_in,
  input wire logic [LINKS*5-1:0] ilas_lane_id_in,
  input wire logic [LINKS-1:0] ilas_adjust_dir_in,
  input wire logic [LINKS-1:0] ilas_phase_adjust_in,
  input wire logic [PAGE_W-1:0] link_page_in,
  output logic [7:0] rx_device_identifier_out,
  output logic [7:0] rx_bank_identifier_out,
  output logic [7:0] rx_lane_identity_out
);

  logic [7:0] did_r [LINKS];
  logic [7:0] bid_r [LINKS];
  logic [7:0] lid_r [LINKS];

  // ------------------------------------------------------------
  // capture per link
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINKS; g++) begin : g_link
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          did_r[g] <= ttr_pkg::REG_RESET;
          bid_r[g] <= ttr_pkg::REG_RESET;
          lid_r[g] <= ttr_pkg::REG_RESET;
        end else if (ilas_valid_in[g]) begin
          did_r[g] <= ilas_device_id_in[g*8 +: 8];
          bid_r[g] <= ilas_bank_id_in[g*8 +: 8];
          lid_r[g] <= {1'b0, ilas_adjust_dir_in[g], ilas_phase_adjust_in[g],
                       ilas_lane_id_in[g*5 +: 5]};
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_device_identifier_out <= ttr_pkg::REG_RESET;
      rx_bank_identifier_out <= ttr_pkg::REG_RESET;
      rx_lane_identity_out <= ttr_pkg::REG_RESET;
    end else if (int'(link_page_in) < LINKS) begin
      rx_device_identifier_out <= did_r[link_page_in];
      rx_bank_identifier_out <= bid_r[link_page_in];
      rx_lane_identity_out <= lid_r[link_page_in];
    end else begin
      rx_device_identifier_out <= ttr_pkg::REG_RESET;
      rx_bank_identifier_out <= ttr_pkg::REG_RESET;
      rx_lane_identity_out <= ttr_pkg::REG_RESET;
    end
  end

endmodule

// file: core/ttr_top.sv
`timescale 1ns/1ps
module ttr_top #(
  parameter int LANES = 8,
  parameter int LANE_W = 32,
  parameter int CHANNELS = 3,
  parameter int SAMPLES = 16,
  parameter int SAMPLE_W = 16,
  parameter int LINKS = 2,
  parameter int PAGE_W = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ttr_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [ttr_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [ttr_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [LANES*LANE_W-1:0] lane_data_in,
  input wire logic lane_valid_in,
  output logic [LANES*LANE_W-1:0] lane_data_out,
  output logic lane_valid_out,
  input wire logic tpl_valid_in,
  input wire logic [CHANNELS*SAMPLES*SAMPLE_W-1:0] tpl_i_in,
  input wire logic [CHANNELS*SAMPLES*SAMPLE_W-1:0] tpl_q_in,
  input wire logic [LINKS-1:0] ilas_valid_in,
  input wire logic [LINKS*8-1:0] ilas_device_id_in,
  input wire logic [LINKS*8-1:0] ilas_bank_id_in,
  input wire logic [LINKS*5-1:0] ilas_lane_id_in,
  input wire logic [LINKS-1:0] ilas_adjust_dir_in,
  input wire logic [LINKS-1:0] ilas_phase_adjust_in,
  output logic test_mismatch_out,
  output logic irq_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [SAMPLE_W-1:0] pick_sample(
    input logic [CHANNELS*SAMPLES*SAMPLE_W-1:0] bank,
    input logic [1:0] channel,
    input logic [3:0] index
  );
    int base;
    base = ((int'(channel) * SAMPLES) + int'(index)) * SAMPLE_W;
    pick_sample = bank[base +: SAMPLE_W];
  endfunction

  function automatic logic hits(
    input logic [ttr_pkg::IDX_W-1:0] idx,
    input logic [ttr_pkg::IDX_W-1:0] target
  );
    hits = (idx == target);
  endfunction

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [3:0] test_sample_index_r;
  logic [1:0] test_channel_select_r;
  logic test_result_clear_r;
  logic test_enable_r;
  logic [7:0] reference_sample_low_r;
  logic [7:0] reference_sample_high_r;
  logic comp_reserved_hi_r;
  logic test_component_select_r;
  logic [4:0] comp_reserved_lo_r;
  logic test_mismatch_flag_r;
  logic [LANES-1:0] lane_invert_mask_r;
  logic [PAGE_W-1:0] link_page_r;
  logic [ttr_pkg::IRQ_W-1:0] irq_status_r;
  logic [ttr_pkg::IRQ_W-1:0] irq_mask_r;
  logic wait_r;
  logic [ttr_pkg::DATA_W-1:0] readdata_r;
  logic irq_r;

  logic [ttr_pkg::IDX_W-1:0] reg_idx;
  logic req;
  logic wr_take;
  logic wr_lane0;
  logic clear_pulse;
  logic [SAMPLE_W-1:0] reference_word;
  logic [SAMPLE_W-1:0] selected_sample;
  logic channel_ok;
  logic mismatch_event;
  logic ilas_event;
  logic [7:0] rx_did;
  logic [7:0] rx_bid;
  logic [7:0] rx_lid;
  logic [ttr_pkg::IRQ_W-1:0] irq_events;
  logic [7:0] read_byte;

  // ------------------------------------------------------------
  // avalon slave handshake
  // ------------------------------------------------------------
  // one idle wait cycle per access keeps read data registered
  assign reg_idx = avs_address_in[ttr_pkg::ADDR_W-1:2];
  assign req = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & ~wait_r;
  assign wr_lane0 = wr_take & avs_byteenable_in[0];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // test control fields
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      test_sample_index_r <= 4'h0;
      test_channel_select_r <= 2'h0;
      test_result_clear_r <= 1'b0;
      test_enable_r <= 1'b0;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_TEST_CONTROL)) begin
      test_sample_index_r <= avs_writedata_in[ttr_pkg::CTRL_SAMPLE_LSB +: 4];
      test_channel_select_r <= avs_writedata_in[ttr_pkg::CTRL_CHANNEL_LSB +: 2];
      test_result_clear_r <= avs_writedata_in[ttr_pkg::CTRL_CLEAR_BIT];
      test_enable_r <= avs_writedata_in[ttr_pkg::CTRL_ENABLE_BIT];
    end
  end

  assign clear_pulse = wr_lane0 && hits(reg_idx, ttr_pkg::IDX_TEST_CONTROL)
    && avs_writedata_in[ttr_pkg::CTRL_CLEAR_BIT];

  // ------------------------------------------------------------
  // reference sample
  // ------------------------------------------------------------
  // reference low byte
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reference_sample_low_r <= ttr_pkg::REG_RESET;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_REF_LOW)) begin
      reference_sample_low_r <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reference_sample_high_r <= ttr_pkg::REG_RESET;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_REF_HIGH)) begin
      reference_sample_high_r <= avs_writedata_in[7:0];
    end
  end

  assign reference_word = {reference_sample_high_r, reference_sample_low_r};

  // ------------------------------------------------------------
  // component select and reserved storage
  // ------------------------------------------------------------
  // reserved bits are read-write here, so they are simply stored
  // i or q select
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      comp_reserved_hi_r <= 1'b0;
      test_component_select_r <= 1'b0;
      comp_reserved_lo_r <= 5'h00;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_COMP_RESULT)) begin
      comp_reserved_hi_r <= avs_writedata_in[7];
      test_component_select_r <= avs_writedata_in[ttr_pkg::COMP_SELECT_BIT];
      comp_reserved_lo_r <= avs_writedata_in[5:1];
    end
  end

  // ------------------------------------------------------------
  // transport layer comparison
  // ------------------------------------------------------------
  // code 3 names no channel, so nothing is compared then
  assign channel_ok = (test_channel_select_r != ttr_pkg::CHANNEL_NONE)
    && (int'(test_channel_select_r) < CHANNELS);

  always_comb begin
    if (!channel_ok) begin
      selected_sample = reference_word;
    end else if (test_component_select_r) begin
      selected_sample = pick_sample(tpl_q_in, test_channel_select_r, test_sample_index_r);
    end else begin
      selected_sample = pick_sample(tpl_i_in, test_channel_select_r, test_sample_index_r);
    end
  end

  assign mismatch_event = test_enable_r && tpl_valid_in && channel_ok
    && (selected_sample != reference_word);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      test_mismatch_flag_r <= 1'b0;
    end else if (mismatch_event) begin
      test_mismatch_flag_r <= 1'b1;
    end else if (clear_pulse) begin
      test_mismatch_flag_r <= 1'b0;
    end
  end

  // relies on constant test pattern
  // a pattern that changes per frame would latch a fail at once

  // ------------------------------------------------------------
  // lane inversion
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lane_invert_mask_r <= '0;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_INV_MASK)) begin
      lane_invert_mask_r <= avs_writedata_in[LANES-1:0];
    end
  end

  ttr_lane_invert #(
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_invert (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .lane_data_in(lane_data_in),
    .lane_valid_in(lane_valid_in),
    .lane_invert_mask_in(lane_invert_mask_r),
    .lane_data_out(lane_data_out),
    .lane_valid_out(lane_valid_out)
  );

  // ------------------------------------------------------------
  // ilas readback
  // ------------------------------------------------------------
  // software selects link page
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      link_page_r <= '0;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_LINK_PAGE)) begin
      link_page_r <= avs_writedata_in[PAGE_W-1:0];
    end
  end

  ttr_ilas_capture #(
    .LINKS(LINKS),
    .PAGE_W(PAGE_W)
  ) u_ilas (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ilas_valid_in(ilas_valid_in),
    .ilas_device_id_in(ilas_device_id_in),
    .ilas_bank_id_in(ilas_bank_id_in),
    .ilas_lane_id_in(ilas_lane_id_in),
    .ilas_adjust_dir_in(ilas_adjust_dir_in),
    .ilas_phase_adjust_in(ilas_phase_adjust_in),
    .link_page_in(link_page_r),
    .rx_device_identifier_out(rx_did),
    .rx_bank_identifier_out(rx_bid),
    .rx_lane_identity_out(rx_lid)
  );

  assign ilas_event = |ilas_valid_in;

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  always_comb begin
    irq_events = ttr_pkg::IRQ_RESET;
    irq_events[ttr_pkg::IRQ_MISMATCH_BIT] = mismatch_event;
    irq_events[ttr_pkg::IRQ_ILAS_BIT] = ilas_event;
  end

  // write one to clear; a same-cycle event keeps its bit set
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_status_r <= ttr_pkg::IRQ_RESET;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_IRQ_STATUS)) begin
      irq_status_r <= (irq_status_r & ~avs_writedata_in[ttr_pkg::IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_r <= irq_status_r | irq_events;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_mask_r <= ttr_pkg::IRQ_RESET;
    end else if (wr_lane0 && hits(reg_idx, ttr_pkg::IDX_IRQ_MASK)) begin
      irq_mask_r <= avs_writedata_in[ttr_pkg::IRQ_W-1:0];
    end
  end

  // one cycle behind status, which keeps the output a flop
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    read_byte = 8'h00;
    unique case (1'b1)
      hits(reg_idx, ttr_pkg::IDX_TEST_CONTROL): begin
        read_byte = {test_sample_index_r, test_channel_select_r,
                     test_result_clear_r, test_enable_r};
      end
      hits(reg_idx, ttr_pkg::IDX_REF_LOW): read_byte = reference_sample_low_r;
      hits(reg_idx, ttr_pkg::IDX_REF_HIGH): read_byte = reference_sample_high_r;
      hits(reg_idx, ttr_pkg::IDX_COMP_RESULT): begin
        read_byte = {comp_reserved_hi_r, test_component_select_r,
                     comp_reserved_lo_r, test_mismatch_flag_r};
      end
      hits(reg_idx, ttr_pkg::IDX_INV_MASK): begin
        read_byte = 8'(lane_invert_mask_r);
      end
      hits(reg_idx, ttr_pkg::IDX_LINK_PAGE): read_byte = 8'(link_page_r);
      hits(reg_idx, ttr_pkg::IDX_IRQ_STATUS): read_byte = 8'(irq_status_r);
      hits(reg_idx, ttr_pkg::IDX_IRQ_MASK): read_byte = 8'(irq_mask_r);
      hits(reg_idx, ttr_pkg::IDX_RX_DEVICE): read_byte = rx_did;
      hits(reg_idx, ttr_pkg::IDX_RX_BANK): read_byte = rx_bid;
      hits(reg_idx, ttr_pkg::IDX_RX_LANE): read_byte = rx_lid;
      default: read_byte = 8'h00;
    endcase
  end

  // data is latched in the wait cycle and held through completion
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      readdata_r <= ttr_pkg::READ_ZERO;
    end else if (avs_read_in && wait_r) begin
      readdata_r <= {24'h000000, read_byte};
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out = readdata_r;
  assign test_mismatch_out = test_mismatch_flag_r;
  assign irq_out = irq_r;

endmodule

// file: verification/ttr_top_props.sv
`timescale 1ns/1ps
// ----------------------------
// port checks for the test block
// ----------------------------
module ttr_top_props #(
  parameter int LANES = 8,
  parameter int LANE_W = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ttr_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [ttr_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [ttr_pkg::DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [LANES*LANE_W-1:0] lane_data_in,
  input wire logic lane_valid_in,
  input wire logic [LANES*LANE_W-1:0] lane_data_out,
  input wire logic lane_valid_out,
  input wire logic tpl_valid_in,
  input wire logic test_mismatch_out
);
  logic clr;
  // clear acts at the completing edge only
  assign clr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
    && avs_writedata_in[1] && avs_address_in[13:2] == ttr_pkg::IDX_TEST_CONTROL;
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  a_wait_one_cycle: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer after one wait cycle");
  a_wait_pulse_only: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low longer than one cycle");
  a_idle_stays_waiting: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("completion without request");
  a_unmapped_reads_zero: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in[13:2] < ttr_pkg::IDX_LINK_PAGE
    |-> avs_readdata_out == ttr_pkg::READ_ZERO) else $error("unmapped read not zero");
  a_lane_valid_delay: assert property (!$past(rst_in) |-> lane_valid_out == $past(lane_valid_in))
    else $error("lane valid not one cycle late");
  a_lane_zero_inverted: assert property (
    !$past(rst_in) |-> lane_data_out[LANE_W-1:0] == $past(lane_data_in[LANE_W-1:0])
    || lane_data_out[LANE_W-1:0] == ~$past(lane_data_in[LANE_W-1:0]))
    else $error("lane 0 neither passed nor inverted");
  a_fail_needs_sample: assert property (
    $rose(test_mismatch_out) |-> $past(tpl_valid_in))
    else $error("fail set without a valid sample");
  a_fail_sticky: assert property (
    $fell(test_mismatch_out) && !$past(rst_in) |-> $past(clr))
    else $error("fail flag dropped without clear");
endmodule

bind ttr_top ttr_top_props #(.LANES(LANES), .LANE_W(LANE_W)) u_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .lane_data_in(lane_data_in), .lane_valid_in(lane_valid_in), .lane_data_out(lane_data_out),
  .lane_valid_out(lane_valid_out), .tpl_valid_in(tpl_valid_in),
  .test_mismatch_out(test_mismatch_out)
);

// file: verification/ttr_tx_model.sv
`timescale 1ns/1ps
// ----------------------------
// transmitter seen from the link
// ----------------------------
module ttr_tx_model (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic [1:0] ilas_go_in,
  output logic tpl_valid_out,
  output logic [767:0] tpl_i_out,
  output logic [767:0] tpl_q_out,
  output logic [255:0] lane_data_out,
  output logic lane_valid_out,
  output logic [1:0] ilas_valid_out,
  output logic [15:0] ilas_device_id_out,
  output logic [15:0] ilas_bank_id_out,
  output logic [9:0] ilas_lane_id_out,
  output logic [1:0] ilas_adjust_dir_out,
  output logic [1:0] ilas_phase_adjust_out
);
  logic [31:0] cnt_r;
  always_ff @(posedge core_clk_in) begin
    cnt_r <= rst_in ? 32'h0 : cnt_r + 32'h1;
  end
  always_comb begin
    for (int k = 0; k < 48; k++) begin
      tpl_i_out[k*16 +: 16] = 16'hA000 + 16'(k);
      tpl_q_out[k*16 +: 16] = 16'h5000 + 16'(3 * k);
    end
  end
  // slow mode leaves every other beat empty
  assign tpl_valid_out = !slow_in || cnt_r[0];
  assign lane_valid_out = cnt_r[1];
  assign lane_data_out = {8{cnt_r ^ 32'h3C5AA5C3}};
  assign ilas_valid_out = ilas_go_in;
  // distinct fields per link; idle lines carry the inverse
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      ilas_device_id_out[l*8 +: 8] = (8'h40 + 8'(l)) ^ {8{!ilas_go_in[l]}};
      ilas_bank_id_out[l*8 +: 8] = (8'h20 + 8'(l)) ^ {8{!ilas_go_in[l]}};
      ilas_lane_id_out[l*5 +: 5] = (5'h11 + 5'(l)) ^ {5{!ilas_go_in[l]}};
      ilas_adjust_dir_out[l] = (l == 1) ^ !ilas_go_in[l];
      ilas_phase_adjust_out[l] = (l == 0) ^ !ilas_go_in[l];
    end
  end
endmodule

// file: verification/tb_transport_test_and_ilas_readback.sv
`timescale 1ns/1ps
module tb_transport_test_and_ilas_readback;
  logic clk, rst, rd, wr, slow, tvalid, lvin, lvout, fail, irq, wait_o;
  logic [13:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] go, iv, ia, ip;
  logic [767:0] ti, tq;
  logic [255:0] lin, lout;
  logic [15:0] idd, ibd;
  logic [9:0] ild;
  int num_errors, checks_done, cyc;
  ttr_top dut (.core_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o), .lane_data_in(lin),
    .lane_valid_in(lvin), .lane_data_out(lout), .lane_valid_out(lvout), .tpl_valid_in(tvalid),
    .tpl_i_in(ti), .tpl_q_in(tq), .ilas_valid_in(iv), .ilas_device_id_in(idd),
    .ilas_bank_id_in(ibd), .ilas_lane_id_in(ild), .ilas_adjust_dir_in(ia),
    .ilas_phase_adjust_in(ip), .test_mismatch_out(fail), .irq_out(irq));
  ttr_tx_model tx (.core_clk_in(clk), .rst_in(rst), .slow_in(slow), .ilas_go_in(go),
    .tpl_valid_out(tvalid), .tpl_i_out(ti), .tpl_q_out(tq), .lane_data_out(lin),
    .lane_valid_out(lvin), .ilas_valid_out(iv), .ilas_device_id_out(idd),
    .ilas_bank_id_out(ibd), .ilas_lane_id_out(ild), .ilas_adjust_dir_out(ia),
    .ilas_phase_adjust_out(ip));
  // ----------------------------
  // bus and compare helpers
  // ----------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle edge first so a release never meets a new request in one step
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic pause();
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [15:0] smp(input int c, input int s, input logic qs);
    return qs ? 16'h5000 + 16'(3 * (c * 16 + s)) : 16'hA000 + 16'(c * 16 + s);
  endfunction
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic t_reset();
    logic [11:0] ix [9] = '{12'h32C, 12'h32D, 12'h32E, 12'h32F, 12'h334, 12'h400, 12'h401,
      12'h402, 12'h3F0};
    chk(fail, 1'b0);
    foreach (ix[k]) rdc(ix[k], 8'h00);
  endtask
  task automatic t_regs();
    bus(1'b1, 12'h32D, 8'hC3);
    bus(1'b1, 12'h32E, 8'h3C);
    bus(1'b1, 12'h334, 8'hA5);
    bus(1'b1, 12'h010, 8'hFF);
    bus(1'b1, 12'h400, 8'hFF);
    rdc(12'h32D, 8'hC3);
    rdc(12'h32E, 8'h3C);
    rdc(12'h334, 8'hA5);
    rdc(12'h010, 8'h00);
    rdc(12'h400, 8'h00);
  endtask
  task automatic t_lanes();
    logic [255:0] d;
    logic [7:0] m = 8'hA5;
    logic v;
    @(negedge clk);
    d = lin;
    v = lvin;
    @(negedge clk);
    chk(lvout, v);
    for (int x = 0; x < 8; x++) chk(lout[x*32 +: 32], d[x*32 +: 32] ^ {32{m[x]}});
  endtask
  task automatic t_tpl();
    logic [15:0] e;
    for (int s = 0; s < 16; s++) begin
      e = smp(s % 3, s, s[0]);
      slow <= s[1];
      bus(1'b1, 12'h32C, 8'h00);
      bus(1'b1, 12'h32F, {1'b0, s[0], 6'h00});
      bus(1'b1, 12'h32D, e[7:0]);
      bus(1'b1, 12'h32E, e[15:8]);
      bus(1'b1, 12'h32C, {s[3:0], 2'(s % 3), 2'b11});
      pause();
      chk(fail, 1'b0);
      bus(1'b1, 12'h32E, ~e[15:8]);
      pause();
      chk(fail, 1'b1);
    end
    rdc(12'h32F, 8'h41);
  endtask
  task automatic t_sticky();
    logic [15:0] e;
    e = smp(0, 15, 1'b1);
    bus(1'b1, 12'h32E, e[15:8]);
    pause();
    chk(fail, 1'b1);
    bus(1'b1, 12'h32C, 8'hF1);
    pause();
    chk(fail, 1'b1);
    bus(1'b1, 12'h32C, 8'hF3);
    pause();
    chk(fail, 1'b0);
    rdc(12'h32F, 8'h40);
    bus(1'b1, 12'h32C, 8'hF0);
    bus(1'b1, 12'h32E, ~e[15:8]);
    pause();
    chk(fail, 1'b0);
    bus(1'b1, 12'h32C, 8'hFD);
    pause();
    chk(fail, 1'b0);
  endtask
  task automatic t_irq();
    rdc(12'h3F0, 8'h01);
    chk(irq, 1'b0);
    bus(1'b1, 12'h3F1, 8'h01);
    pause();
    chk(irq, 1'b1);
    bus(1'b1, 12'h3F0, 8'h01);
    pause();
    chk(irq, 1'b0);
    rdc(12'h3F0, 8'h00);
  endtask
  task automatic t_ilas();
    @(posedge clk);
    go <= 2'b01;
    @(posedge clk);
    go <= 2'b10;
    @(posedge clk);
    go <= 2'b00;
    rdc(12'h3F0, 8'h02);
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, 12'h300, 8'(l));
      rdc(12'h400, 8'h40 + 8'(l));
      rdc(12'h401, 8'h20 + 8'(l));
      rdc(12'h402, l == 1 ? 8'h52 : 8'h31);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {rst, rd, wr, slow, go, addr, wdata} = {1'b1, 51'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_lanes();
    t_tpl();
    t_sticky();
    t_irq();
    t_ilas();
    final_report();
  end
endmodule
